/* File: idw_pkg.sv */
// Package: constants of the identify parameter words 48 to 82 block
// Operation
// R1 - Word 48 reads zero, no dword I/O
// R2 - Word 49 sets flow-control ready bits 11, 10
// R3 - Word 50 reads 4000h, valid marker
// R4 - Words 51, 52 return legacy timing 0200h
// R5 - Word 53 bits 2..0 set, rest zero
// R6 - Words 54-58 current geometry, capacity low first
// R7 - Word 59 valid bit plus multiple count
// R8 - Words 60-61 user sectors, saturated above 28 bits
// R9 - Word 63 modes supported and selected bits
// R10 - At most one DMA mode selected
// R11 - Word 64 reads 0003h, PIO 3 and 4
// R12 - Word 65 minimum DMA cycle 120 ns
// R13 - Word 66 recommended DMA cycle 120 ns
// R14 - Word 67 PIO cycle 240 ns, no flow control
// R15 - Word 68 PIO cycle 120 ns, flow control
// R16 - Word 80 major version bitmap 007ch
// R17 - Word 81 minor version code 0019h
// R18 - Word 82 reports command set 746bh
// R19 - Protected area, security, SMART bits clearable
// R20 - Word 47 bounds the multiple count
// R21 - Words delivered ascending, 16 bits each
package idw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GEOM = 8'h04;
  localparam logic [7:0] OFS_CAP_CUR = 8'h08;
  localparam logic [7:0] OFS_CAP_USER = 8'h0c;
  localparam logic [7:0] OFS_MODE = 8'h10;
  localparam logic [7:0] OFS_READ = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_WORD_BASE = 8'h40;
  // Word range
  localparam logic [6:0] WORD_FIRST = 7'h30;
  localparam logic [6:0] WORD_LAST = 7'h52;
  // Constant words
  localparam logic [15:0] W48_DWORD_IO = 16'h0000;
  localparam logic [15:0] W49_CAPS = 16'h0c00;
  localparam logic [15:0] W50_CAPS = 16'h4000;
  localparam logic [15:0] W51_PIO_TIMING = 16'h0200;
  localparam logic [15:0] W52_DMA_TIMING = 16'h0200;
  localparam logic [15:0] W53_VALID = 16'h0007;
  localparam logic [15:0] W59_VALID_BIT = 16'h0100;
  localparam logic [15:0] W63_SUPPORTED = 16'h0007;
  localparam logic [15:0] W64_ADV_PIO = 16'h0003;
  localparam logic [15:0] W65_DMA_MIN_NS = 16'h0078;
  localparam logic [15:0] W66_DMA_REC_NS = 16'h0078;
  localparam logic [15:0] W67_PIO_NS = 16'h00f0;
  localparam logic [15:0] W68_PIO_FC_NS = 16'h0078;
  localparam logic [15:0] W80_MAJOR = 16'h007c;
  localparam logic [15:0] W81_MINOR = 16'h0019;
  localparam logic [15:0] W82_CMDSET = 16'h746b;
  localparam logic [15:0] W82_CLEARABLE = 16'h0403;
  // Multiple count limit from word 47 low byte
  localparam logic [7:0] MULT_MAX = 8'h10;
  localparam logic [27:0] LBA28_SAT = 28'hfffffff;
  // Reset values
  localparam logic [15:0] RST_CYLS = 16'h3fff;
  localparam logic [15:0] RST_HEADS = 16'h0010;
  localparam logic [15:0] RST_SPT = 16'h003f;
  localparam logic [31:0] RST_CAP = 32'h00fbfc10;
  localparam logic [1:0] DMA_MODE_NONE = 2'h3;
  // Control register fields
  localparam int CTRL_HPA_OFF = 0;
  localparam int CTRL_SEC_OFF = 1;
  localparam int CTRL_SMART_OFF = 2;
  localparam int CTRL_START = 8;
  // Reader states
  typedef enum logic [1:0] {
    IDW_IDLE = 2'b01,
    IDW_SEND = 2'b10
  } idw_state_e;
endpackage : idw_pkg

/* File: idw_table.sv */
// Identify words 48 to 82 table, AHB-Lite register slave and word streamer
`timescale 1ns/100ps
`default_nettype none
module idw_table
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [15:0] word_data,
  output logic word_valid,
  input wire logic word_ready,
  output logic word_last
);

  //////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  logic ap_wr, ap_rd, next_ap_wr, next_ap_rd;
  logic [7:0] ap_addr, next_ap_addr;
  logic take;

  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase latch
  always_comb
  begin
    next_ap_wr = take && hwrite;
    next_ap_rd = take && !hwrite;
    next_ap_addr = take ? haddr : ap_addr;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_addr <= 8'h00;
    end
    else
    begin
      ap_wr <= next_ap_wr;
      ap_rd <= next_ap_rd;
      ap_addr <= next_ap_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Live drive settings written by firmware
  logic [2:0] feat_off, next_feat_off;
  logic [15:0] cyls, heads, spt, next_cyls, next_heads, next_spt;
  logic [31:0] cap_cur, next_cap_cur;
  logic [47:0] native_max, next_native_max;
  logic mult_valid, next_mult_valid;
  logic [7:0] mult_cnt, next_mult_cnt;
  logic [1:0] dma_mode, next_dma_mode;
  logic start;

  assign start = ap_wr && (ap_addr == idw_pkg::OFS_CTRL)
    && hwdata[idw_pkg::CTRL_START];

  // Register writes
  always_comb
  begin
    next_feat_off = feat_off;
    next_cyls = cyls;
    next_heads = heads;
    next_spt = spt;
    next_cap_cur = cap_cur;
    next_native_max = native_max;
    next_mult_valid = mult_valid;
    next_mult_cnt = mult_cnt;
    next_dma_mode = dma_mode;
    if (ap_wr)
    begin
      case (ap_addr)
        idw_pkg::OFS_CTRL:
          next_feat_off = hwdata[2:0];
        idw_pkg::OFS_GEOM:
        begin
          next_cyls = hwdata[15:0];
          next_heads = {8'h00, hwdata[23:16]};
          next_spt = {8'h00, hwdata[31:24]};
        end
        idw_pkg::OFS_CAP_CUR:
          next_cap_cur = hwdata;
        idw_pkg::OFS_CAP_USER:
          next_native_max = {16'h0000, hwdata};
        idw_pkg::OFS_MODE:
        begin
          // R20 - count bounded by word 47
          if (hwdata[7:0] <= idw_pkg::MULT_MAX)
          begin
            next_mult_cnt = hwdata[7:0];
            next_mult_valid = hwdata[8];
          end
          // R10 - single selected mode
          next_dma_mode = hwdata[17:16];
        end
        default:
          next_feat_off = feat_off;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      feat_off <= 3'h0;
      cyls <= idw_pkg::RST_CYLS;
      heads <= idw_pkg::RST_HEADS;
      spt <= idw_pkg::RST_SPT;
      cap_cur <= idw_pkg::RST_CAP;
      native_max <= {16'h0000, idw_pkg::RST_CAP};
      mult_valid <= 1'b0;
      mult_cnt <= 8'h00;
      dma_mode <= idw_pkg::DMA_MODE_NONE;
    end
    else
    begin
      feat_off <= next_feat_off;
      cyls <= next_cyls;
      heads <= next_heads;
      spt <= next_spt;
      cap_cur <= next_cap_cur;
      native_max <= next_native_max;
      mult_valid <= next_mult_valid;
      mult_cnt <= next_mult_cnt;
      dma_mode <= next_dma_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Word table lookup
  logic [27:0] user_sect;
  logic [15:0] w63_sel, w82;

  // R8 - saturate above 28 bits
  assign user_sect = (native_max[47:28] != 20'h00000) ? idw_pkg::LBA28_SAT
    : native_max[27:0];
  // R9 - selected mode bits
  assign w63_sel = (dma_mode == idw_pkg::DMA_MODE_NONE) ? 16'h0000
    : (16'h0100 << dma_mode);
  // R19 - overlay clears features
  assign w82 = idw_pkg::W82_CMDSET & ~{5'h00, feat_off[0], 8'h00,
    feat_off[1], feat_off[2]};

  function automatic logic [15:0] word_at(input logic [6:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      // R1 - no dword I/O
      7'd48: w = idw_pkg::W48_DWORD_IO;
      // R2 - flow control ready
      7'd49: w = idw_pkg::W49_CAPS;
      // R3 - word valid marker
      7'd50: w = idw_pkg::W50_CAPS;
      // R4 - legacy timing modes
      7'd51: w = idw_pkg::W51_PIO_TIMING;
      7'd52: w = idw_pkg::W52_DMA_TIMING;
      // R5 - validity flags
      7'd53: w = idw_pkg::W53_VALID;
      // R6 - current geometry words
      7'd54: w = cyls;
      7'd55: w = heads;
      7'd56: w = spt;
      7'd57: w = cap_cur[15:0];
      7'd58: w = cap_cur[31:16];
      // R7 - multiple setting word
      7'd59: w = (mult_valid ? idw_pkg::W59_VALID_BIT : 16'h0000)
        | {8'h00, mult_cnt};
      7'd60: w = user_sect[15:0];
      7'd61: w = {4'h0, user_sect[27:16]};
      7'd63: w = idw_pkg::W63_SUPPORTED | w63_sel;
      // R11 - advanced PIO modes
      7'd64: w = idw_pkg::W64_ADV_PIO;
      // R12 - minimum DMA cycle
      7'd65: w = idw_pkg::W65_DMA_MIN_NS;
      // R13 - recommended DMA cycle
      7'd66: w = idw_pkg::W66_DMA_REC_NS;
      // R14 - PIO cycle unpaced
      7'd67: w = idw_pkg::W67_PIO_NS;
      // R15 - PIO cycle paced
      7'd68: w = idw_pkg::W68_PIO_FC_NS;
      // R16 - major version bitmap
      7'd80: w = idw_pkg::W80_MAJOR;
      // R17 - minor version code
      7'd81: w = idw_pkg::W81_MINOR;
      // R18 - command set word
      7'd82: w = w82;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : word_at

  //////////////////////////////////////////////////////////////////////////
  // Streamer of words 48 to 82
  idw_pkg::idw_state_e state, next_state;
  logic [6:0] idx, next_idx;
  logic [15:0] next_word_data;
  logic busy;

  assign busy = (state == idw_pkg::IDW_SEND);
  assign word_valid = busy;
  assign word_last = busy && (idx == idw_pkg::WORD_LAST);

  // R21 - ascending word order
  always_comb
  begin
    next_state = state;
    next_idx = idx;
    next_word_data = word_data;
    case (state)
      idw_pkg::IDW_IDLE:
        if (start)
        begin
          next_state = idw_pkg::IDW_SEND;
          next_idx = idw_pkg::WORD_FIRST;
          next_word_data = word_at(idw_pkg::WORD_FIRST);
        end
      idw_pkg::IDW_SEND:
        if (word_ready)
        begin
          if (idx == idw_pkg::WORD_LAST)
            next_state = idw_pkg::IDW_IDLE;
          else
          begin
            next_idx = idx + 7'd1;
            next_word_data = word_at(idx + 7'd1);
          end
        end
      default:
        next_state = idw_pkg::IDW_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= idw_pkg::IDW_IDLE;
      idx <= idw_pkg::WORD_FIRST;
      word_data <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      word_data <= next_word_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data
  logic [31:0] next_hrdata;
  logic [7:0] win_ofs;
  logic [6:0] rd_idx;

  // One aligned 32-bit slot per identify word
  assign win_ofs = ap_addr - idw_pkg::OFS_WORD_BASE;
  assign rd_idx = {1'b0, win_ofs[7:2]};

  always_comb
  begin
    next_hrdata = 32'h0000_0000;
    if (ap_rd)
    begin
      if (ap_addr >= idw_pkg::OFS_WORD_BASE)
        next_hrdata = {16'h0000, word_at(rd_idx + idw_pkg::WORD_FIRST)};
      else
        case (ap_addr)
          idw_pkg::OFS_CTRL: next_hrdata = {29'h0, feat_off};
          idw_pkg::OFS_GEOM: next_hrdata = {spt[7:0], heads[7:0], cyls};
          idw_pkg::OFS_CAP_CUR: next_hrdata = cap_cur;
          idw_pkg::OFS_CAP_USER: next_hrdata = native_max[31:0];
          idw_pkg::OFS_MODE: next_hrdata = {14'h0, dma_mode, 7'h0,
            mult_valid, mult_cnt};
          idw_pkg::OFS_STATUS: next_hrdata = {24'h0, busy, idx};
          default: next_hrdata = 32'h0000_0000;
        endcase
    end
  end

  // Read data, driven combinationally from the latched address, not registered
  assign hrdata = next_hrdata;
endmodule : idw_table
`default_nettype wire

/* File: idw_table_chk.sv */
// Checker of the identify word stream
`timescale 1ns/100ps
`default_nettype none
module idw_table_chk
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] word_data,
  input wire logic word_valid,
  input wire logic word_ready,
  input wire logic word_last
);
  logic [5:0] idx;
  logic [5:0] next_idx;
  logic acc;
  // Index of the word on offer
  assign acc = word_valid && word_ready;
  always_comb
  begin
    next_idx = 6'h0;
    if (word_valid)
      next_idx = acc ? idx + 6'h1 : idx;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      idx <= 6'h0;
    else
      idx <= next_idx;
  end
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////////////
  first_word_a: assert property ($rose(word_valid) |->
    word_data == 16'h0000) else $error("first word not zero");
  hold_word_a: assert property (word_valid && !word_ready |=>
    word_valid && $stable(word_data)) else $error("word not held");
  last_pos_a: assert property (word_valid && word_last |-> idx == 6'd34)
    else $error("last flag misplaced");
  last_drop_a: assert property (acc && word_last |=> !word_valid)
    else $error("stream did not end");
  dma_one_a: assert property (word_valid && idx == 6'd15 |->
    $onehot0(word_data[10:8]) && {word_data[15:11], word_data[7:0]} == 13'h7)
    else $error("dma word wrong");
  mult_lim_a: assert property (word_valid && idx == 6'd11 |->
    word_data[15:9] == 7'h0 && word_data[7:0] <= 8'h10)
    else $error("multiple word wrong");
  cmd_set_a: assert property (word_valid && word_last |->
    (word_data | 16'h0403) == 16'h746b) else $error("command set wrong");
  cycle_time_a: assert property (
    word_valid && idx >= 6'd17 && idx <= 6'd20
    |-> word_data == (idx == 6'd19 ? 16'h00f0 : 16'h0078))
    else $error("cycle time wrong");
  cover property (acc && word_last);
  cover property (word_valid && !word_ready);
  cover property (word_valid && idx == 6'd15 && word_data[10]);
endmodule : idw_table_chk
bind idw_table idw_table_chk idw_table_chk_inst (.hclk(hclk),
  .hresetn(hresetn), .word_data(word_data), .word_valid(word_valid),
  .word_ready(word_ready), .word_last(word_last));
`default_nettype wire

/* File: idw_host_model.sv */
// Host adapter model that takes the identify words
`timescale 1ns/100ps
`default_nettype none
module idw_host_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic [15:0] word_data,
  input wire logic word_valid,
  input wire logic word_last,
  output logic word_ready
);
  logic [15:0] words [0:34];
  int n;
  int last_n;
  int streams;
  // Accept words in order, stalling at random when slow
  // host paces words
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      word_ready <= 1'b0;
      n <= 0;
      streams <= 0;
    end
    else
    begin
      word_ready <= slow ? ($urandom % 4 == 0) : 1'b1;
      if (word_valid && word_ready)
      begin
        if (n < 35)
          words[n] <= word_data;
        n <= word_last ? 0 : n + 1;
        if (word_last)
          last_n <= n;
        if (word_last)
          streams <= streams + 1;
      end
    end
  end
endmodule : idw_host_model
`default_nettype wire

/* File: identify_parameter_words_48_to_82_test.sv */
// Testbench of the identify word table
`timescale 1ns/100ps
`default_nettype none
module identify_parameter_words_48_to_82_test;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd_q, rd, geom, capc, capu;
  logic [15:0] word_data;
  logic word_valid, word_ready, word_last, vld, v;
  logic [7:0] cnt, c;
  logic [1:0] dma;
  logic [2:0] clr;
  int num_errors, total_checks, s, wr;
  idw_table idw_table_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready),
    .word_last(word_last));
  idw_host_model idw_host_model_inst (.hclk(hclk), .hresetn(hresetn),
    .slow(slow), .word_data(word_data), .word_valid(word_valid),
    .word_last(word_last), .word_ready(word_ready));
  always #5 hclk = ~hclk;
  always @(posedge hclk) rd_q <= hrdata;
  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One single transfer, read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    #1 r = rd_q;
  endtask : bus
  function automatic logic [15:0] exp_word(input int w);
    logic [31:0] u;
    u = capu[31:28] != 4'h0 ? 32'h0fffffff : capu;
    case (w)
      49: return 16'h0c00;
      50: return 16'h4000;
      51, 52: return 16'h0200;
      53: return 16'h0007;
      54: return geom[15:0];
      55: return {8'h0, geom[23:16]};
      56: return {8'h0, geom[31:24]};
      57: return capc[15:0];
      58: return capc[31:16];
      59: return {7'h0, vld, cnt};
      60: return u[15:0];
      61: return u[31:16];
      63: return 16'h0007 | (dma == 2'h3 ? 16'h0 : 16'h0100 << dma);
      64: return 16'h0003;
      65, 66, 68: return 16'h0078;
      67: return 16'h00f0;
      80: return 16'h007c;
      81: return 16'h0019;
      82: return 16'h746b & ~{5'h0, clr[0], 8'h0, clr[1], clr[2]};
      default: return 16'h0000;
    endcase
  endfunction : exp_word
  // Watchdog
  initial
  begin
    #200000;
    num_errors++;
    report_and_stop;
  end
  // Main sequence
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    slow = 1'b0;
    void'($urandom(32'hec39));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, idw_pkg::OFS_GEOM, 32'h0, rd);
    chk("geom", 32'h3f103fff, rd);
    bus(1'b0, idw_pkg::OFS_CAP_CUR, 32'h0, rd);
    chk("cap", 32'h00fbfc10, rd);
    bus(1'b1, 8'h14, 32'hffffffff, rd);
    bus(1'b0, 8'h14, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 8; i++)
    begin
      geom = $urandom;
      capc = $urandom;
      capu = i == 1 ? 32'h0fffffff : i == 2 ? 32'h10000000 : $urandom;
      c = i == 0 ? 8'h10 : i == 3 ? 8'h11 : 8'($urandom % 20);
      v = 1'($urandom);
      dma = i < 4 ? 2'(i) : 2'($urandom);
      clr = 3'($urandom);
      slow <= i[0];
      if (c <= 8'h10)
        {vld, cnt} = {v, c};
      bus(1'b1, idw_pkg::OFS_GEOM, geom, rd);
      bus(1'b1, idw_pkg::OFS_CAP_CUR, capc, rd);
      bus(1'b1, idw_pkg::OFS_CAP_USER, capu, rd);
      bus(1'b1, idw_pkg::OFS_MODE, {14'h0, dma, 7'h0, v, c}, rd);
      bus(1'b0, idw_pkg::OFS_MODE, 32'h0, rd);
      chk("mode", {14'h0, dma, 7'h0, vld, cnt}, rd);
      s = idw_host_model_inst.streams;
      bus(1'b1, idw_pkg::OFS_CTRL, {23'h0, 1'b1, 5'h0, clr}, rd);
      for (int k = 0; k < 2000 && idw_host_model_inst.streams == s; k++)
        @(posedge hclk);
      chk("streams", s + 1, idw_host_model_inst.streams);
      chk("count", 32'd34, idw_host_model_inst.last_n);
      for (int w = 48; w <= 82; w++)
        chk($sformatf("word%0d", w), exp_word(w),
          idw_host_model_inst.words[w - 48]);
      bus(1'b0, idw_pkg::OFS_STATUS, 32'h0, rd);
      chk("status", {24'h0, 1'b0, idw_pkg::WORD_LAST}, rd);
      bus(1'b0, idw_pkg::OFS_CTRL, 32'h0, rd);
      chk("ctrl", {29'h0, clr}, rd);
      wr = 48 + $urandom % 35;
      bus(1'b0, 8'(idw_pkg::OFS_WORD_BASE + 4 * (wr - 48)), 32'h0, rd);
      chk("window", {16'h0, exp_word(wr)}, rd);
    end
    report_and_stop;
  end
endmodule : identify_parameter_words_48_to_82_test
`default_nettype wire
